// ### lpm_clk_ctrl.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "lpm_defines.svh"
module lpm_clk_ctrl #(
   parameter int LFXT_DIV = `LPM_LFXT_DIV_CYC,
   parameter int DCO_DLY = `LPM_DCO_DLY_CYC,
   parameter bit LFXT_OFF_DIS = 1'b0
) (
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic IRQ_ACCEPT,
   input wire logic RETURN_EXEC,
   input wire lpm_pkg::lpm_sw_t RETURN_WORD,
   output logic STACK_PUSH,
   output lpm_pkg::lpm_sw_t STACK_WORD,
   output lpm_pkg::lpm_sw_t STATUS_WORD,
   output logic CPU_HALT,
   output logic MCLK_EN,
   output logic SUBCLK_EN,
   output logic ACLK_EN,
   output lpm_pkg::lpm_clk_t CLK_STATE
);
   import lpm_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_n;

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // status word, clock selects and bus slave
   // ----------------------------------------------------------------
   lpm_sw_t sw_ff, nxt_sw;
   logic [2:0] sel_ff, nxt_sel;
   lpm_sw_t push_word_ff, nxt_push_word;
   logic push_ff, nxt_push;
   logic [31:0] prdata_ff, nxt_prdata;
   logic err_ff, nxt_err;
   lpm_clk_t state_ff, nxt_state;
   logic setup_ph, wr_acc, hit;
   logic [31:0] rd_mux;

   assign setup_ph = PSEL && !PENABLE;
   assign wr_acc = PSEL && PENABLE && PWRITE;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (PADDR)
         `LPM_ADDR_SW: rd_mux = {16'h0000, sw_ff};
         `LPM_ADDR_SEL: rd_mux = {29'h0000_0000, sel_ff};
         `LPM_ADDR_STAT: rd_mux = {25'h000_0000, state_ff};
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt_sw = sw_ff;
      nxt_sel = sel_ff;
      nxt_push = 1'b0;
      nxt_push_word = push_word_ff;
      nxt_prdata = prdata_ff;
      nxt_err = err_ff;
      if (setup_ph) begin
         nxt_err = !hit;
         nxt_prdata = rd_mux;
      end
      if (wr_acc && PADDR == `LPM_ADDR_SW) begin
         nxt_sw = lpm_sw_t'(PWDATA[15:0] & `LPM_SW_MASK);
      end
      if (wr_acc && PADDR == `LPM_ADDR_SEL) begin
         nxt_sel = PWDATA[2:0];
      end
      if (RETURN_EXEC) begin
         nxt_sw = lpm_sw_t'(RETURN_WORD & `LPM_SW_MASK);
      end
      if (IRQ_ACCEPT) begin
         nxt_push = 1'b1;
         nxt_push_word = sw_ff;
         nxt_sw.cpu_clock_off = 1'b0;
         nxt_sw.low_freq_osc_off = 1'b0;
         nxt_sw.dc_generator_off = 1'b0;
         nxt_sw.sub_clock_gate = 1'b0;
         nxt_sw.global_irq_enable = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sw_ff <= lpm_sw_t'(`LPM_SW_RESET);
         sel_ff <= `LPM_SEL_RESET;
         push_ff <= 1'b0;
         push_word_ff <= lpm_sw_t'(`LPM_SW_RESET);
         prdata_ff <= 32'h0000_0000;
         err_ff <= 1'b0;
      end else begin
         sw_ff <= nxt_sw;
         sel_ff <= nxt_sel;
         push_ff <= nxt_push;
         push_word_ff <= nxt_push_word;
         prdata_ff <= nxt_prdata;
         err_ff <= nxt_err;
      end
   end

   assign PRDATA = prdata_ff;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && err_ff;
   assign STACK_PUSH = push_ff;
   assign STACK_WORD = push_word_ff;
   assign STATUS_WORD = sw_ff;
   assign CPU_HALT = sw_ff.cpu_clock_off;

   // ----------------------------------------------------------------
   // oscillator control
   // ----------------------------------------------------------------
   logic main_on, sub_on, dco_main, dco_sub, lf_main, lf_sub;
   logic dco_on, dcgen_on, lfxt_on;

   assign main_on = !sw_ff.cpu_clock_off;
   assign sub_on = !sw_ff.sub_clock_gate;
   assign dco_main = main_on && !sel_ff[`LPM_MAIN_SEL_HI_BIT];
   assign dco_sub = sub_on && !sel_ff[`LPM_SUB_SEL_BIT];
   assign lf_main = main_on && sel_ff[`LPM_MAIN_SEL_HI_BIT];
   assign lf_sub = sub_on && sel_ff[`LPM_SUB_SEL_BIT];
   assign dco_on = dco_main || dco_sub;
   assign dcgen_on = !sw_ff.dc_generator_off || dco_on;
   assign lfxt_on = !sw_ff.low_freq_osc_off || lf_main || lf_sub || LFXT_OFF_DIS;

   // ----------------------------------------------------------------
   // oscillator restart delay
   // ----------------------------------------------------------------
   logic dco_ok_ff, nxt_dco_ok;
   logic [15:0] dly_cnt_ff, nxt_dly_cnt;
   logic dco_tick;

   always_comb begin
      nxt_dco_ok = dco_ok_ff;
      nxt_dly_cnt = dly_cnt_ff;
      if (!dco_on) begin
         nxt_dly_cnt = 16'h0000;
         if (!dcgen_on) begin
            nxt_dco_ok = 1'b0;
         end
      end else if (!dco_ok_ff) begin
         nxt_dly_cnt = dly_cnt_ff + 16'h0001;
         if (dly_cnt_ff == 16'(DCO_DLY - 1)) begin
            nxt_dco_ok = 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         dco_ok_ff <= 1'b1;
         dly_cnt_ff <= 16'h0000;
      end else begin
         dco_ok_ff <= nxt_dco_ok;
         dly_cnt_ff <= nxt_dly_cnt;
      end
   end

   assign dco_tick = dco_on && dco_ok_ff;

   // ----------------------------------------------------------------
   // crystal rate divider
   // ----------------------------------------------------------------
   logic [15:0] div_cnt_ff, nxt_div_cnt;
   logic lf_tick;

   assign lf_tick = lfxt_on && div_cnt_ff == 16'(LFXT_DIV - 1);

   always_comb begin
      nxt_div_cnt = div_cnt_ff;
      if (!lfxt_on || lf_tick) begin
         nxt_div_cnt = 16'h0000;
      end else begin
         nxt_div_cnt = div_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_ff <= 16'h0000;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   // ----------------------------------------------------------------
   // clock enables
   // ----------------------------------------------------------------
   logic mclk_ff, nxt_mclk, subclk_ff, nxt_subclk, aclk_ff, nxt_aclk;

   always_comb begin
      nxt_aclk = lf_tick;
      nxt_mclk = main_on && (sel_ff[`LPM_MAIN_SEL_HI_BIT] ? lf_tick : dco_tick);
      nxt_subclk = sub_on && (sel_ff[`LPM_SUB_SEL_BIT] ? lf_tick : dco_tick);
      nxt_state.lfxt_run = lfxt_on;
      nxt_state.dcgen_on = dcgen_on;
      nxt_state.dco_ready = dco_ok_ff;
      nxt_state.dco_run = dco_on;
      nxt_state.aclk_run = lfxt_on;
      nxt_state.subclk_run = sub_on;
      nxt_state.mclk_run = main_on;
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         mclk_ff <= 1'b0;
         subclk_ff <= 1'b0;
         aclk_ff <= 1'b0;
         state_ff <= lpm_clk_t'(7'h00);
      end else begin
         mclk_ff <= nxt_mclk;
         subclk_ff <= nxt_subclk;
         aclk_ff <= nxt_aclk;
         state_ff <= nxt_state;
      end
   end

   assign MCLK_EN = mclk_ff;
   assign SUBCLK_EN = subclk_ff;
   assign ACLK_EN = aclk_ff;
   assign CLK_STATE = state_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!rst_n);

   chk_push_on_irq: assert property (
      IRQ_ACCEPT |=> STACK_PUSH && STACK_WORD == $past(sw_ff))
      else $error("status word not pushed on interrupt");
   chk_wake_irq: assert property (
      IRQ_ACCEPT |=> !CPU_HALT && !sw_ff.sub_clock_gate)
      else $error("interrupt did not wake the system");
   chk_return_load: assert property (
      RETURN_EXEC && !IRQ_ACCEPT |=> sw_ff[8:0] == $past(RETURN_WORD[8:0]))
      else $error("return did not reload the stacked word");
   chk_sub_gate: assert property (
      sw_ff.sub_clock_gate |=> !SUBCLK_EN)
      else $error("sub-system clock ran while gated");
   chk_dcgen_off: assert property (
      !dcgen_on |-> sw_ff.dc_generator_off && !dco_main && !dco_sub)
      else $error("dc generator off while still needed");
   chk_dco_keep: assert property (
      dco_main || dco_sub |-> dco_on)
      else $error("oscillator stopped while feeding a clock");
   chk_dco_stop: assert property (
      !dco_main && !dco_sub |=> !MCLK_EN || sel_ff[1] || $past(sel_ff[1]))
      else $error("main clock ran from a stopped oscillator");
   chk_dco_delay: assert property (
      !dcgen_on |=> !dco_tick)
      else $error("oscillator ticked before restart delay");
   chk_lfxt_keep: assert property (
      !sw_ff.low_freq_osc_off || lf_main || lf_sub |-> lfxt_on)
      else $error("crystal stopped while required");
   chk_lfxt_perm: assert property (
      LFXT_OFF_DIS |-> lfxt_on)
      else $error("crystal stopped despite build option");
   chk_main_stop: assert property (
      sw_ff.cpu_clock_off |-> CPU_HALT ##1 !MCLK_EN)
      else $error("main clock ran while cpu off");
   chk_rsvd_zero: assert property (
      STATUS_WORD.rsvd == 7'h00)
      else $error("reserved status bits not zero");
   chk_aclk_src: assert property (
      ACLK_EN |-> $past(lfxt_on) && $past(div_cnt_ff) == 16'(LFXT_DIV - 1))
      else $error("aux clock without crystal tick");

   cov_irq_wake: cover property (CPU_HALT ##1 IRQ_ACCEPT ##1 !CPU_HALT);
   cov_return_sleep: cover property (RETURN_EXEC && RETURN_WORD.cpu_clock_off ##1 CPU_HALT);
   cov_dco_restart: cover property (!dco_ok_ff && dco_on ##1 dco_ok_ff);
   cov_lfxt_off: cover property (!lfxt_on);

endmodule // lpm_clk_ctrl

// ### lpm_defines.svh
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define LPM_ADDR_SW 12'h000
`define LPM_ADDR_SEL 12'h004
`define LPM_ADDR_STAT 12'h008

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define LPM_SW_RESET 16'h0000
`define LPM_SW_MASK 16'h01FF
`define LPM_SEL_RESET 3'h0
`define LPM_MAIN_SEL_HI_BIT 1
`define LPM_SUB_SEL_BIT 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LPM_CLK_NS 10
`define LPM_CORE_HZ 100000000
`define LPM_DCO_DLY_NS 1000
`define LPM_DCO_DLY_CYC ((`LPM_DCO_DLY_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`define LPM_LFXT_HZ 32768
`define LPM_LFXT_DIV_CYC (`LPM_CORE_HZ / `LPM_LFXT_HZ)

`endif

// ### lpm_pkg.sv
package lpm_pkg;

   // ----------------------------------------------------------------
   // status word layout
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [6:0] rsvd;
      logic ovf;
      logic sub_clock_gate;
      logic dc_generator_off;
      logic low_freq_osc_off;
      logic cpu_clock_off;
      logic global_irq_enable;
      logic neg;
      logic zero;
      logic carry;
   } lpm_sw_t;

   // ----------------------------------------------------------------
   // clock system state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic lfxt_run;
      logic dcgen_on;
      logic dco_ready;
      logic dco_run;
      logic aclk_run;
      logic subclk_run;
      logic mclk_run;
   } lpm_clk_t;

endpackage

// ### lpm_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// cpu core side: interrupt entry, stack and return
// ----------------------------------------------------------------
module lpm_cpu_model (
   input wire logic CORE_CLK,
   input wire logic STACK_PUSH,
   input wire lpm_pkg::lpm_sw_t STACK_WORD,
   output logic IRQ_ACCEPT,
   output logic RETURN_EXEC,
   output lpm_pkg::lpm_sw_t RETURN_WORD
);
   import lpm_pkg::*;
   lpm_sw_t stk[$];
   initial begin
      IRQ_ACCEPT = 1'b0;
      RETURN_EXEC = 1'b0;
      RETURN_WORD = 16'h0000;
   end
   always @(posedge CORE_CLK) begin
      if (STACK_PUSH === 1'b1) stk.push_back(STACK_WORD);
   end
   task automatic irq();
      @(posedge CORE_CLK);
      IRQ_ACCEPT <= 1'b1;
      @(posedge CORE_CLK);
      IRQ_ACCEPT <= 1'b0;
   endtask
   // handler may edit the stacked copy before returning
   task automatic irq_return(input logic [15:0] clr);
      lpm_sw_t w;
      @(posedge CORE_CLK);
      w = stk.pop_back() & ~clr;
      RETURN_WORD <= w;
      RETURN_EXEC <= 1'b1;
      @(posedge CORE_CLK);
      RETURN_EXEC <= 1'b0;
      // popped word is stale once the return is taken
      RETURN_WORD <= ~w;
   endtask
endmodule // lpm_cpu_model

// ### tb_top.sv
`timescale 1ns/1ps
`include "lpm_defines.svh"
module tb_top;
   import lpm_pkg::*;
   localparam int DIV = 4;
   localparam int DLY = 3;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, m, s, a;
   logic irq, ret_x, push, halt, m_en, s_en, a_en;
   lpm_sw_t ret_w, stk_w, sw;
   lpm_clk_t cs, cs2;
   int dly;
   int bad_count = 0;
   int n_tests = 0;
   lpm_clk_ctrl #(.LFXT_DIV(DIV), .DCO_DLY(DLY)) i_lpm_clk_ctrl (
      .CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .IRQ_ACCEPT(irq), .RETURN_EXEC(ret_x),
      .RETURN_WORD(ret_w), .STACK_PUSH(push), .STACK_WORD(stk_w),
      .STATUS_WORD(sw), .CPU_HALT(halt), .MCLK_EN(m_en), .SUBCLK_EN(s_en),
      .ACLK_EN(a_en), .CLK_STATE(cs));
   // crystal can never be stopped in this build
   lpm_clk_ctrl #(.LFXT_DIV(DIV), .DCO_DLY(DLY), .LFXT_OFF_DIS(1'b1)) i_lpm_clk_ctrl_keep (
      .CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
      .PREADY(), .PSLVERR(), .IRQ_ACCEPT(irq), .RETURN_EXEC(ret_x),
      .RETURN_WORD(ret_w), .STACK_PUSH(), .STACK_WORD(), .STATUS_WORD(),
      .CPU_HALT(), .MCLK_EN(), .SUBCLK_EN(), .ACLK_EN(), .CLK_STATE(cs2));
   lpm_cpu_model i_lpm_cpu_model (
      .CORE_CLK(clk), .STACK_PUSH(push), .STACK_WORD(stk_w),
      .IRQ_ACCEPT(irq), .RETURN_EXEC(ret_x), .RETURN_WORD(ret_w));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      if (i == 16) begin
         bad_count++;
         results();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      cmp("prdata", exp, q);
   endtask
   task automatic cnt(input int n);
      m = 0;
      s = 0;
      a = 0;
      repeat (n) begin
         @(negedge clk);
         m = m + m_en;
         s = s + s_en;
         a = a + a_en;
      end
   endtask
   task automatic wait_m(output int cyc);
      int i;
      for (i = 0; i < 64; i++) begin
         @(negedge clk);
         if (m_en === 1'b1) break;
      end
      cyc = i;
      if (i == 64) begin
         bad_count++;
         results();
      end
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`LPM_ADDR_SW, 32'h0);
      rd(`LPM_ADDR_SEL, 32'h0);
      cnt(8);
      cmp("mclk", 8, m);
      cmp("subclk", 8, s);
      cmp("aclk", 8 / DIV, a);
      $display("test reset done");
      apb(1'b1, `LPM_ADDR_SW, 32'h0000FFFF);
      rd(`LPM_ADDR_SW, 32'h000001FF);
      repeat (2) @(negedge clk);
      cmp("halt", 1, halt);
      cnt(8);
      cmp("mclk", 0, m);
      cmp("subclk", 0, s);
      cmp("aclk", 0, a);
      cmp("dco_run", 0, cs.dco_run);
      cmp("dcgen_on", 0, cs.dcgen_on);
      cmp("lfxt_run", 0, cs.lfxt_run);
      cmp("lfxt_keep", 1, cs2.lfxt_run);
      apb(1'b0, 12'h00C, 32'h0);
      cmp("pslverr", 1, e);
      cmp("prdata", 0, q);
      $display("test sleep done");
      i_lpm_cpu_model.irq();
      @(negedge clk);
      cmp("push", 1, push);
      cmp("stack", 16'h01FF, stk_w);
      cmp("sw", 16'h0107, sw);
      cmp("halt", 0, halt);
      cmp("mclk_early", 0, m_en);
      wait_m(dly);
      cmp("dco_delay", DLY, dly);
      cnt(8);
      cmp("mclk", 8, m);
      $display("test wake done");
      i_lpm_cpu_model.irq_return(16'h0000);
      repeat (2) @(negedge clk);
      cmp("sw", 16'h01FF, sw);
      cmp("halt", 1, halt);
      i_lpm_cpu_model.irq();
      repeat (2) @(negedge clk);
      i_lpm_cpu_model.irq_return(16'h0010);
      repeat (2) @(negedge clk);
      cmp("sw", 16'h01EF, sw);
      cmp("halt", 0, halt);
      wait_m(dly);
      cmp("dco_keep", 0, dly);
      cnt(8);
      cmp("mclk", 8, m);
      cmp("subclk", 0, s);
      cmp("dco_run", 1, cs.dco_run);
      $display("test return done");
      apb(1'b1, `LPM_ADDR_SEL, 32'h00000002);
      repeat (2) @(negedge clk);
      cnt(16);
      cmp("mclk", 16 / DIV, m);
      cmp("lfxt_run", 1, cs.lfxt_run);
      cmp("dco_run", 0, cs.dco_run);
      cmp("dcgen_on", 0, cs.dcgen_on);
      apb(1'b1, `LPM_ADDR_SEL, 32'h00000004);
      apb(1'b1, `LPM_ADDR_SW, 32'h00000070);
      repeat (2) @(negedge clk);
      cnt(16);
      cmp("mclk", 0, m);
      cmp("subclk", 16 / DIV, s);
      cmp("lfxt_run", 1, cs.lfxt_run);
      cmp("dco_run", 0, cs.dco_run);
      $display("test crystal done");
      results();
   end
endmodule // tb_top
